// ===== verilog/watchdog_pkg.sv
package watchdog_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RELOAD_U = 8'h04;
	localparam logic [7:0] OFS_RELOAD_H = 8'h08;
	localparam logic [7:0] OFS_RELOAD_L = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_REFRESH = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] OFS_CAUSE = 8'h20;
	// unlock keys
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
	// counter figures
	localparam int CNT_W = 24;
	localparam logic [23:0] RELOAD_RST = 24'h000400;
	localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
	// status bit positions
	localparam int IRQ_EXPIRY_BIT = 0;
	localparam int IRQ_IGNORED_BIT = 1;
	localparam int CAUSE_WD_BIT = 0;
	localparam int CAUSE_STOP_BIT = 1;
	// timing: 10 ns clock, 10 kHz oscillator
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_PERIOD_NS = 100000;
	localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic resp_irq;
	} ctrl_t;

	typedef struct packed {
		logic stop;
		logic wd;
	} cause_t;

	typedef enum logic {
		WD_OFF = 1'b0,
		WD_ON = 1'b1
	} wd_state_t;

	typedef enum logic [2:0] {
		LK_LOCKED = 3'b000,
		LK_KEY1 = 3'b001,
		LK_WANT_U = 3'b011,
		LK_WANT_H = 3'b010,
		LK_WANT_L = 3'b110
	} lock_state_t;
endpackage : watchdog_pkg

// ===== verilog/watchdog_rc_osc.sv
// free-running tick source standing in for the dedicated rc oscillator;
// nothing in the watchdog can stop or restart it
module watchdog_rc_osc import watchdog_pkg::*; #(
	parameter int DIV = OSC_DIV_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// tick
	output logic tick_o
);
	if (DIV < 2) begin : g_div_check
		$error("oscillator divider must be at least 2");
	end

	logic [31:0] div_cnt;
	logic [31:0] next_div_cnt;
	logic next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_div_cnt = div_cnt + 32'h00000001;
		if (div_cnt == 32'(DIV - 1)) begin
			next_div_cnt = 32'h00000000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt <= 32'h00000000;
			tick_o <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick_o <= next_tick;
		end
	end
endmodule : watchdog_rc_osc

// ===== verilog/watchdog_reload_lock.sv
// guards the reload bytes; advances only on writes that take effect
module watchdog_reload_lock import watchdog_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// write events
	input wire logic wr_i,
	input wire logic [7:0] wr_ofs_i,
	input wire logic [7:0] wr_byte_i,
	// decisions
	output logic accept_o,
	output logic key_write_o
);
	lock_state_t state;
	lock_state_t next_state;
	logic is_ctrl;

	assign is_ctrl = wr_ofs_i == OFS_CTRL;

	always_comb begin
		next_state = state;
		accept_o = 1'b0;
		key_write_o = 1'b0;
		if (wr_i) begin
			next_state = LK_LOCKED;
			unique case (state)
				LK_LOCKED: begin
					if (is_ctrl && wr_byte_i == UNLOCK_KEY1) begin
						next_state = LK_KEY1;
						key_write_o = 1'b1;
					end
				end
				LK_KEY1: begin
					if (is_ctrl && wr_byte_i == UNLOCK_KEY2) begin
						next_state = LK_WANT_U;
						key_write_o = 1'b1;
					end
				end
				LK_WANT_U: begin
					if (wr_ofs_i == OFS_RELOAD_U) begin
						next_state = LK_WANT_H;
						accept_o = 1'b1;
					end
				end
				LK_WANT_H: begin
					if (wr_ofs_i == OFS_RELOAD_H) begin
						next_state = LK_WANT_L;
						accept_o = 1'b1;
					end
				end
				LK_WANT_L: begin
					if (wr_ofs_i == OFS_RELOAD_L) begin
						accept_o = 1'b1;
					end
				end
				default: next_state = LK_LOCKED;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= LK_LOCKED;
		end else begin
			state <= next_state;
		end
	end
endmodule : watchdog_reload_lock

// ===== verilog/watchdog_timer.sv
// watchdog core with classic wishbone register slave
module watchdog_timer import watchdog_pkg::*; #(
	parameter int AW = 8,
	parameter int OSC_DIV = OSC_DIV_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// device context
	input wire logic always_on_option_i,
	input wire logic stop_mode_i,
	// actions
	output logic system_reset_o,
	output logic stop_recovery_o,
	output logic irq_o,
	output logic watchdog_on_o
);
	// parameter checks refuse what the logic cannot serve
	if (AW < 6) begin : g_aw_check
		$error("address width must reach the register map");
	end
	if (OSC_DIV < 2) begin : g_div_check
		$error("oscillator divider must be at least 2");
	end
	// count, reload bytes and read word all assume three bytes
	if (CNT_W != 24) begin : g_width_check
		$error("counter width must be three reload bytes");
	end
	// a reset reload under four expires before software can act
	if (RELOAD_RST < 24'h000004) begin : g_reload_check
		$error("reset reload value below the minimum");
	end
	// a floor at or above the smallest reload refuses every refresh
	if (REFRESH_FLOOR >= 24'h000004) begin : g_floor_check
		$error("refresh floor blocks every refresh");
	end
	if (IRQ_EXPIRY_BIT > 1 || IRQ_IGNORED_BIT > 1) begin : g_bit_check
		$error("status bits must fit the two-bit registers");
	end
	if (UNLOCK_KEY1 == UNLOCK_KEY2) begin : g_key_check
		$error("unlock keys must differ");
	end

	// bus decode
	logic req;
	logic wr_take;
	logic wr_lane0;
	logic [7:0] ofs;
	logic [7:0] wbyte;
	logic [7:0] lock_ofs;
	logic next_ack;
	logic [31:0] next_dat;

	// register state
	ctrl_t ctrl;
	ctrl_t next_ctrl;
	logic [7:0] reload_u;
	logic [7:0] reload_h;
	logic [7:0] reload_l;
	logic [7:0] next_reload_u;
	logic [7:0] next_reload_h;
	logic [7:0] next_reload_l;
	logic [1:0] irq_status;
	logic [1:0] next_irq_status;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_mask;
	cause_t cause;
	cause_t next_cause;
	logic next_irq;

	// counter state
	wd_state_t wd_state;
	wd_state_t next_wd_state;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic started;
	logic next_started;
	logic next_sys_rst;
	logic next_stop_rec;

	// events
	logic tick;
	logic lock_accept;
	logic key_write;
	logic refresh_req;
	logic refresh_ok;
	logic refresh_ignored;
	logic expire;
	logic [CNT_W-1:0] reload_val;

	assign req = wb_cyc_i && wb_stb_i;
	// a write lands at the edge where the master sees ack
	assign wr_take = req && wb_ack_o && wb_we_i;
	assign wr_lane0 = wr_take && wb_sel_i[0];
	assign ofs = 8'(wb_adr_i);
	assign wbyte = wb_dat_i[7:0];
	// a write without lane 0 still relocks; steered to a read-only offset
	// it can never count as a key or a reload byte
	assign lock_ofs = wb_sel_i[0] ? ofs : OFS_COUNT;
	assign reload_val = {reload_u, reload_h, reload_l};

	watchdog_rc_osc #(
		.DIV(OSC_DIV)
	) osc_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	watchdog_reload_lock lock_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(wr_take),
		.wr_ofs_i(lock_ofs),
		.wr_byte_i(wbyte),
		.accept_o(lock_accept),
		.key_write_o(key_write)
	);

	// bus answer: ack one cycle after the request, dropped the next
	always_comb begin
		next_ack = req && !wb_ack_o;
		next_dat = 32'h00000000;
		unique case (ofs)
			OFS_CTRL: next_dat[0] = ctrl.resp_irq;
			OFS_RELOAD_U: next_dat[7:0] = reload_u;
			OFS_RELOAD_H: next_dat[7:0] = reload_h;
			OFS_RELOAD_L: next_dat[7:0] = reload_l;
			OFS_COUNT: next_dat[CNT_W-1:0] = count;
			OFS_IRQ_STATUS: next_dat[1:0] = irq_status;
			OFS_IRQ_MASK: next_dat[1:0] = irq_mask;
			OFS_CAUSE: next_dat[1:0] = cause;
			default: next_dat = 32'h00000000;
		endcase
		if (!next_ack) begin
			next_dat = wb_dat_o;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// refresh handling; near expiry a refresh is too late and is flagged
	assign refresh_req = wr_take && ofs == OFS_REFRESH;
	assign refresh_ignored = refresh_req && wd_state == WD_ON &&
		count <= REFRESH_FLOOR;
	assign refresh_ok = refresh_req && !refresh_ignored;
	// expiry is the tick that finds one count or none left
	assign expire = wd_state == WD_ON && tick && count <= 24'h000001;

	// counter and on/off state
	always_comb begin
		next_wd_state = wd_state;
		next_count = count;
		next_started = 1'b1;
		next_sys_rst = 1'b0;
		next_stop_rec = 1'b0;
		// the option strap counts only on the first edge out of reset
		if (!started && always_on_option_i) begin
			next_wd_state = WD_ON;
			next_count = reload_val;
		end
		unique case (wd_state)
			WD_OFF: begin
				if (refresh_ok) begin
					next_wd_state = WD_ON;
					next_count = reload_val;
				end
			end
			WD_ON: begin
				if (refresh_ok) begin
					next_count = reload_val;
				end else if (expire) begin
					// stays on and starts a fresh period after acting once
					next_count = reload_val;
					if (!ctrl.resp_irq) begin
						next_sys_rst = !stop_mode_i;
						next_stop_rec = stop_mode_i;
					end
				end else if (tick) begin
					next_count = count - 24'h000001;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wd_state <= WD_OFF;
			count <= 24'h000000;
			started <= 1'b0;
			system_reset_o <= 1'b0;
			stop_recovery_o <= 1'b0;
			watchdog_on_o <= 1'b0;
		end else begin
			wd_state <= next_wd_state;
			count <= next_count;
			started <= next_started;
			system_reset_o <= next_sys_rst;
			stop_recovery_o <= next_stop_rec;
			watchdog_on_o <= next_wd_state == WD_ON;
		end
	end

	// control, reload and mask registers
	always_comb begin
		next_ctrl = ctrl;
		next_reload_u = reload_u;
		next_reload_h = reload_h;
		next_reload_l = reload_l;
		next_irq_mask = irq_mask;
		if (wr_lane0) begin
			unique case (ofs)
				OFS_CTRL: begin
					if (!key_write) begin
						next_ctrl.resp_irq = wbyte[0];
					end
				end
				OFS_RELOAD_U: begin
					if (lock_accept) next_reload_u = wbyte;
				end
				OFS_RELOAD_H: begin
					if (lock_accept) next_reload_h = wbyte;
				end
				OFS_RELOAD_L: begin
					if (lock_accept) next_reload_l = wbyte;
				end
				OFS_IRQ_MASK: next_irq_mask = wbyte[1:0];
				default: next_irq_mask = irq_mask;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl <= '0;
			reload_u <= RELOAD_RST[23:16];
			reload_h <= RELOAD_RST[15:8];
			reload_l <= RELOAD_RST[7:0];
			irq_mask <= 2'h0;
		end else begin
			ctrl <= next_ctrl;
			reload_u <= next_reload_u;
			reload_h <= next_reload_h;
			reload_l <= next_reload_l;
			irq_mask <= next_irq_mask;
		end
	end

	// sticky status and reset cause; a set in the clearing cycle wins
	always_comb begin
		next_irq_status = irq_status;
		next_cause = cause;
		if (wr_lane0 && ofs == OFS_IRQ_STATUS) begin
			next_irq_status = irq_status & ~wbyte[1:0];
		end
		if (wr_lane0 && ofs == OFS_CAUSE) begin
			next_cause = cause & ~cause_t'(wbyte[1:0]);
		end
		if (expire && ctrl.resp_irq) begin
			next_irq_status[IRQ_EXPIRY_BIT] = 1'b1;
		end
		if (refresh_ignored) begin
			next_irq_status[IRQ_IGNORED_BIT] = 1'b1;
		end
		if (expire && !ctrl.resp_irq) begin
			next_cause.wd = 1'b1;
			if (stop_mode_i) next_cause.stop = 1'b1;
		end
		// a new mask acts with its write, not a cycle later
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// cause flags survive the pulse on system_reset_o; only sys_rst_i or a write of ones to OFS_CAUSE clears them
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_status <= 2'h0;
			cause <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			cause <= next_cause;
			irq_o <= next_irq;
		end
	end
endmodule : watchdog_timer

// ===== verif/watchdog_timer_assertions.sv
module watchdog_timer_assertions (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// device
	input wire logic stop_mode_i,
	input wire logic system_reset_o,
	input wire logic stop_recovery_o,
	input wire logic watchdog_on_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence quiet_s;
		!system_reset_o [*8];
	endsequence
	ack_reply_a: assert property (req_s |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	data_width_a: assert property (
		wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
		else $error("read data above 24 bits");
	on_sticky_a: assert property (watchdog_on_o |=> watchdog_on_o)
		else $error("watchdog turned off");
	reset_once_a: assert property (system_reset_o |=> quiet_s)
		else $error("reset pulse repeated");
	reset_normal_a: assert property (
		system_reset_o |-> !$past(stop_mode_i) && !stop_recovery_o)
		else $error("reset in stop mode");
	stop_recover_a: assert property (
		stop_recovery_o |-> $past(stop_mode_i) && !system_reset_o)
		else $error("recovery outside stop mode");
	act_when_on_a: assert property (
		(system_reset_o || stop_recovery_o) |-> $past(watchdog_on_o))
		else $error("action while off");
endmodule : watchdog_timer_assertions

bind watchdog_timer watchdog_timer_assertions u_chk (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.stop_mode_i(stop_mode_i),
	.system_reset_o(system_reset_o),
	.stop_recovery_o(stop_recovery_o),
	.watchdog_on_o(watchdog_on_o)
);

// ===== verif/watchdog_timer_24bit_tb_top.sv
module watchdog_timer_24bit_tb_top import watchdog_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic aon = 1'b0;
	logic stop = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] dat_o;
	logic ack, rst_o, rec_o, irq, on;
	int errors = 0;
	int comparisons = 0;
	int cyc_n = 0;
	int pulses = 0;
	int n_wait, t0, p0;
	logic [7:0] ra [9] = '{OFS_CTRL, OFS_RELOAD_U, OFS_RELOAD_H,
		OFS_RELOAD_L, OFS_COUNT, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_CAUSE,
		8'h40};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};

	// short divider keeps each time-out near a hundred cycles
	watchdog_timer #(.OSC_DIV(8)) i_dut (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(dat),
		.wb_dat_o(dat_o),
		.wb_ack_o(ack),
		.always_on_option_i(aon),
		.stop_mode_i(stop),
		.system_reset_o(rst_o),
		.stop_recovery_o(rec_o),
		.irq_o(irq),
		.watchdog_on_o(on)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task conclude;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	always @(posedge clk_i) begin
		cyc_n++;
		if (rst_o === 1'b1)
			pulses++;
		if (cyc_n == 20000) begin
			errors++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		dat <= d;
		// only the bench timeout ends this wait
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		@(posedge clk_i);
	endtask : xfer

	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, {24'h0, e});
	endtask : rd

	// 0 reset pulse, 1 stop recovery, 2 interrupt
	task await(input int k, input int lim);
		n_wait = 0;
		while ((k == 0 ? rst_o : k == 1 ? rec_o : irq) !== 1'b1 &&
			n_wait < lim) begin
			@(posedge clk_i);
			n_wait++;
		end
		chk(n_wait < lim, 1'b1);
	endtask : await

	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ra[i])
			rd(ra[i], rv[i]);
		chk(on, 1'b0);
		wr(OFS_RELOAD_U, 8'h12);
		rd(OFS_RELOAD_U, 8'h00);
		wr(OFS_CTRL, UNLOCK_KEY1);
		wr(OFS_CTRL, UNLOCK_KEY2);
		wr(OFS_RELOAD_U, 8'h01);
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_RELOAD_H, 8'h07);
		rd(OFS_RELOAD_U, 8'h01);
		rd(OFS_RELOAD_H, 8'h04);
		wr(OFS_CTRL, UNLOCK_KEY1);
		wr(OFS_CTRL, UNLOCK_KEY2);
		wr(OFS_RELOAD_U, 8'h00);
		wr(OFS_RELOAD_H, 8'h00);
		wr(OFS_RELOAD_L, 8'h10);
		rd(OFS_RELOAD_L, 8'h10);
		rd(OFS_CTRL, 8'h00);
		wr(OFS_REFRESH, 8'h00);
		t0 = cyc_n;
		chk(on, 1'b1);
		xfer(1'b0, OFS_COUNT, 32'h0);
		chk(q >= 15 && q <= 16, 1'b1);
		await(0, 200);
		chk(cyc_n - t0 >= 112 && cyc_n - t0 <= 132, 1'b1);
		rd(OFS_CAUSE, 8'h01);
		wr(OFS_CAUSE, 8'h03);
		stop <= 1'b1;
		await(1, 200);
		stop <= 1'b0;
		rd(OFS_CAUSE, 8'h03);
		wr(OFS_CAUSE, 8'h03);
		// poll is faster than a tick, so the value 2 is never skipped
		do
			xfer(1'b0, OFS_COUNT, 32'h0);
		while (q !== 32'h2);
		wr(OFS_REFRESH, 8'h00);
		await(0, 40);
		rd(OFS_IRQ_STATUS, 8'h02);
		wr(OFS_IRQ_STATUS, 8'h03);
		wr(OFS_CAUSE, 8'h03);
		wr(OFS_CTRL, 8'h01);
		wr(OFS_IRQ_MASK, 8'h01);
		p0 = pulses;
		wr(OFS_REFRESH, 8'h00);
		await(2, 200);
		chk(pulses, p0);
		rd(OFS_IRQ_STATUS, 8'h01);
		rd(OFS_CAUSE, 8'h00);
		wr(OFS_IRQ_MASK, 8'h00);
		@(posedge clk_i);
		chk(irq, 1'b0);
		wr(OFS_IRQ_STATUS, 8'h01);
		rd(OFS_IRQ_STATUS, 8'h00);
		aon <= 1'b1;
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(on, 1'b1);
		xfer(1'b0, OFS_COUNT, 32'h0);
		chk(q >= 32'(RELOAD_RST) - 32'h1 && q <= 32'(RELOAD_RST), 1'b1);
		rd(OFS_CTRL, 8'h00);
		conclude();
	end
endmodule : watchdog_timer_24bit_tb_top
